// ---- hdl/thp_host_port.sv ----
`timescale 1ns/1ps
module thp_host_port
  import thp_pkg::*;
#(
  parameter logic [RST_W-1:0] RESET_PROC_CYCLES = RESET_PROC_DEF
) (
  input  wire logic       CLK_I,
  input  wire logic       SYS_RST_I,
  input  wire logic       HOST_RST_I,
  input  wire logic       START_I,
  input  wire thp_cmd_t   CMD_I,
  input  wire logic [2:0] MUX_SELECT_I,
  input  wire logic       XFER_ACK_I,
  input  wire logic       STOP_I,
  input  wire logic [8:0] DATA_I,
  output logic      [8:0] DATA_O,
  output logic            DATA_OE_O,
  output logic            BUSY_O,
  output logic            XFER_REQUEST_O,
  output logic            EXPECTING_DATA_O,
  output logic            BLOCK_SENSED_O,
  output logic            END_OF_DATA_PULSE_O,
  output logic            OSC_OUT_O,
  output logic            ID_BURST_ACTIVE_O,
  output logic            TAPE_MARK_O,
  output logic            REJECT_O,
  output logic            OP_INCOMPLETE_O,
  output logic            OVERRUN_FLAG_O,
  output logic            STATUS_CHANGE_O,
  output logic            DATA_CHECK_FLAG_O,
  output logic      [8:0] ERROR_BUS_O,
  output logic            ENG_CMD_VALID_O,
  output thp_cmd_t        ENG_CMD_O,
  output logic            ENG_ABORT_O,
  output logic            ENG_STOP_O,
  input  wire logic       ENG_DONE_I,
  input  wire logic       ENG_REJECT_I,
  input  wire logic [5:0] ENG_REJ_CODE_I,
  input  wire logic       ENG_OP_INCOMPLETE_I,
  input  wire thp_evt_t   ENG_EVT_I,
  input  wire logic       ENG_ID_ACTIVE_I,
  input  wire logic       ENG_DIAG_SET_I,
  input  wire logic [1:0] ENG_DIAG_AID_I,
  input  wire logic       ENG_PULSE_A_I,
  input  wire logic [8:0] ENG_DEAD_I,
  input  wire thp_sense_t ENG_SENSE_I,
  input  wire logic       ENG_RD_VALID_I,
  input  wire logic [7:0] ENG_RD_DATA_I,
  input  wire logic       ENG_RD_LAST_I,
  output logic            ENG_RD_READY_O,
  output logic            ENG_WR_VALID_O,
  output logic      [7:0] ENG_WR_DATA_O,
  output logic            ENG_WR_LAST_O,
  input  wire logic       ENG_WR_READY_I
);

  //----------------------------------------------------------------------------
  // Helper functions
  //----------------------------------------------------------------------------

  // Bus line k carries byte bit 7-k
  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    r = '0;
    for (int k = 0; k < 8; k++) begin
      r[k] = v[7-k];
    end
    return r;
  endfunction : rev8

  // Parity bit that makes the nine lines odd
  function automatic logic odd_par(input logic [7:0] v);
    return ~(^v);
  endfunction : odd_par

  function automatic logic is_read_cmd(input thp_cmd_t c);
    return (c == CMD_READ_FWD) || (c == CMD_READ_BWD);
  endfunction : is_read_cmd

  //----------------------------------------------------------------------------
  // State
  //----------------------------------------------------------------------------

  typedef struct packed {
    thp_xst_t               xst;
    logic                   busy;
    logic                   in_reset;
    logic [RST_W-1:0]       rst_cnt;
    logic                   abort;
    thp_cmd_t               cmd;
    logic                   cmd_pulse;
    logic                   stop_pulse;
    logic                   exp_data;
    logic                   wr_done;
    logic                   tape_mark;
    logic                   reject;
    logic                   op_incomplete;
    logic                   overrun;
    logic                   stat_chg;
    logic                   data_check_flag;
    logic                   id_hold;
    logic                   id_out;
    logic                   diag;
    thp_rw_err_t            rw;
    logic [8:0]             dead;
    logic [5:0]             rej_code;
    logic [CNT_W-1:0]       blk_cnt;
    logic                   blk_out;
    logic [CNT_W-1:0]       end_cnt;
    logic                   end_out;
    logic [1:0]             osc_cnt;
    logic                   osc;
    logic                   prev_online;
    logic                   prev_ready;
    thp_char_t [1:0]        fifo;
    logic [1:0]             fifo_last;
    logic                   wp;
    logic                   rp;
    logic [1:0]             cnt;
    logic                   rd_ready;
    logic                   wr_valid;
    thp_char_t              wr_head;
    logic                   wr_last;
    logic                   req;
    logic                   drv;
    thp_char_t              dout;
    logic                   dout_last;
    logic [CNT_W-1:0]       setup_cnt;
    logic [8:0]             err_bus;
  } thp_state_t;

  thp_state_t s_r;
  thp_state_t s_nxt;
  logic       accept;
  logic       push;
  logic       pop;
  thp_char_t  push_c;
  logic       push_last;
  logic       strobe;
  logic       clr_tm;
  logic       clr_sc;
  logic       dchk_set;

  //----------------------------------------------------------------------------
  // Next-state logic
  //----------------------------------------------------------------------------

  always_comb begin
    s_nxt           = s_r;
    s_nxt.cmd_pulse = 1'b0;
    s_nxt.stop_pulse = 1'b0;
    push            = 1'b0;
    pop             = 1'b0;
    push_c          = '0;
    push_last       = 1'b0;
    strobe          = XFER_ACK_I | STOP_I;

    // Command acceptance only while idle
    accept = START_I & ~s_r.busy & ~HOST_RST_I;
    clr_tm = accept & (CMD_I != CMD_DRIVE_CLEAR) & (CMD_I != CMD_SENSE)
                    & (CMD_I != CMD_NO_OP);
    clr_sc = accept & (CMD_I != CMD_SENSE) & (CMD_I != CMD_NO_OP);
    if (accept) begin
      s_nxt.busy      = 1'b1;
      s_nxt.cmd       = CMD_I;
      s_nxt.cmd_pulse = 1'b1;
      s_nxt.exp_data  = (CMD_I == CMD_WRITE_BLOCK) | (CMD_I == CMD_LOOP_WR);
      s_nxt.wr_done   = 1'b0;
      s_nxt.xst       = XS_IDLE;
    end else if (s_r.busy & ~s_r.in_reset & (ENG_DONE_I | ENG_REJECT_I)) begin
      s_nxt.busy = 1'b0;
    end

    // Sticky flags: a same-cycle set wins over the clear at start
    dchk_set = ENG_EVT_I.crc | ENG_EVT_I.write_tape_mark_cmd | ENG_EVT_I.uncorrectable_err
             | ENG_EVT_I.partial_record | ENG_EVT_I.multi_track_err
             | ENG_EVT_I.end_data_err | ENG_EVT_I.velocity_err | ENG_EVT_I.overrun
             | ENG_EVT_I.bot_backward | ENG_EVT_I.pe_postamble
             | ENG_EVT_I.pe_track_err;
    s_nxt.data_check_flag  = (s_r.data_check_flag & ~accept) | dchk_set;
    s_nxt.overrun   = (s_r.overrun & ~accept) | ENG_EVT_I.overrun;
    s_nxt.tape_mark = (s_r.tape_mark & ~clr_tm) | ENG_EVT_I.tape_mark;
    s_nxt.reject    = (s_r.reject & ~accept) | ENG_REJECT_I;
    s_nxt.op_incomplete    = (s_r.op_incomplete & ~accept) | (ENG_REJECT_I & ENG_OP_INCOMPLETE_I);
    s_nxt.id_hold   = (s_r.id_hold & ~accept) | ENG_EVT_I.id_fail
                    | ENG_EVT_I.bot_backward;
    s_nxt.dead      = (s_r.dead & {9{~accept}}) | ENG_DEAD_I;
    s_nxt.rw.crc    = (s_r.rw.crc & ~accept) | ENG_EVT_I.crc;
    s_nxt.rw.write_tape_mark_cmd    = (s_r.rw.write_tape_mark_cmd & ~accept) | ENG_EVT_I.write_tape_mark_cmd;
    s_nxt.rw.uncorrectable_err = (s_r.rw.uncorrectable_err & ~accept)
                               | ENG_EVT_I.uncorrectable_err;
    s_nxt.rw.partial_record    = (s_r.rw.partial_record & ~accept)
                               | ENG_EVT_I.partial_record;
    s_nxt.rw.multi_track_err   = (s_r.rw.multi_track_err & ~accept)
                               | ENG_EVT_I.multi_track_err;
    s_nxt.rw.end_data_err      = (s_r.rw.end_data_err & ~accept) | ENG_EVT_I.end_data_err;
    s_nxt.rw.velocity_err      = (s_r.rw.velocity_err & ~accept) | ENG_EVT_I.velocity_err;
    s_nxt.rw.unused            = 1'b0;
    s_nxt.diag      = s_r.diag | ENG_DIAG_SET_I;
    s_nxt.rw.diag_latch = s_nxt.diag;
    if (ENG_REJECT_I) begin
      s_nxt.rej_code = ENG_REJ_CODE_I;
    end

    // Drive status changes
    s_nxt.prev_online = ENG_SENSE_I.online;
    s_nxt.prev_ready  = ENG_SENSE_I.ready;
    s_nxt.stat_chg = (s_r.stat_chg & ~clr_sc)
                   | (ENG_SENSE_I.online ^ s_r.prev_online)
                   | (ENG_SENSE_I.ready & ~s_r.prev_ready);

    // Block sensed pulse
    if (s_r.blk_cnt != '0) begin
      s_nxt.blk_cnt = s_r.blk_cnt - 1'b1;
    end
    if (ENG_EVT_I.block) begin
      s_nxt.blk_cnt = BLOCK_PULSE_CYC;
    end
    if (s_r.end_cnt != '0) begin
      s_nxt.end_cnt = s_r.end_cnt - 1'b1;
    end

    // Oscillator divider
    if (s_r.osc_cnt == OSC_HALF_CYC - 2'h1) begin
      s_nxt.osc_cnt = '0;
      s_nxt.osc     = ~s_r.osc;
    end else begin
      s_nxt.osc_cnt = s_r.osc_cnt + 2'h1;
    end

    // Character handshake
    case (s_r.xst)
      XS_IDLE: begin
        if (s_r.busy & ~accept & ~s_r.in_reset) begin
          if (s_r.exp_data) begin
            if ((s_r.cnt < 2'h2) & ~s_r.wr_done) begin
              s_nxt.req = 1'b1;
              s_nxt.xst = XS_REQ;
            end
          end else if (s_r.cnt != 2'h0) begin
            pop             = 1'b1;
            s_nxt.dout      = s_r.fifo[s_r.rp];
            s_nxt.dout_last = s_r.fifo_last[s_r.rp];
            s_nxt.drv       = 1'b1;
            s_nxt.setup_cnt = SETUP_CYC;
            s_nxt.xst       = XS_SETUP;
          end
        end
      end
      XS_SETUP: begin
        // Data stands on the bus before the request rises
        if (s_r.setup_cnt <= 4'h1) begin
          s_nxt.req = 1'b1;
          s_nxt.xst = XS_REQ;
        end else begin
          s_nxt.setup_cnt = s_r.setup_cnt - 1'b1;
        end
      end
      XS_REQ: begin
        if (strobe) begin
          s_nxt.req = 1'b0;
          s_nxt.xst = XS_REL;
          if (s_r.exp_data) begin
            push      = 1'b1;
            push_c    = '{par: DATA_I[8], val: rev8(DATA_I[7:0])};
            push_last = STOP_I;
            s_nxt.wr_done = STOP_I;
          end else begin
            s_nxt.stop_pulse = STOP_I;
            if ((s_r.dout_last | STOP_I) & is_read_cmd(s_r.cmd)) begin
              s_nxt.end_cnt = END_PULSE_CYC;
            end
          end
        end
      end
      XS_REL: begin
        s_nxt.drv = 1'b0;
        if (~strobe) begin
          s_nxt.xst = XS_IDLE;
        end
      end
      default: s_nxt.xst = XS_IDLE;
    endcase

    // Read characters enter from the engine
    if (~s_r.exp_data & ENG_RD_VALID_I & s_r.rd_ready) begin
      push      = 1'b1;
      push_c    = '{par: odd_par(ENG_RD_DATA_I), val: ENG_RD_DATA_I};
      push_last = ENG_RD_LAST_I;
    end
    if (s_r.exp_data & s_r.wr_valid & ENG_WR_READY_I) begin
      pop = 1'b1;
    end

    // Two-entry buffer bookkeeping
    if (push) begin
      s_nxt.fifo[s_r.wp]      = push_c;
      s_nxt.fifo_last[s_r.wp] = push_last;
      s_nxt.wp                = ~s_r.wp;
    end
    if (pop) begin
      s_nxt.rp = ~s_r.rp;
    end
    s_nxt.cnt = s_r.cnt + {1'b0, push} - {1'b0, pop};

    // Host reset: abort, clear status, leave diagnostic mode
    if (HOST_RST_I) begin
      s_nxt.busy      = 1'b1;
      s_nxt.in_reset  = 1'b1;
      s_nxt.rst_cnt   = RESET_PROC_CYCLES;
      s_nxt.abort     = 1'b1;
      s_nxt.diag      = 1'b0;
      s_nxt.rw        = '0;
      s_nxt.exp_data  = 1'b0;
      s_nxt.tape_mark = 1'b0;
      s_nxt.reject    = 1'b0;
      s_nxt.op_incomplete    = 1'b0;
      s_nxt.overrun   = 1'b0;
      s_nxt.stat_chg  = 1'b0;
      s_nxt.data_check_flag  = 1'b0;
      s_nxt.id_hold   = 1'b0;
      s_nxt.blk_cnt   = '0;
      s_nxt.end_cnt   = '0;
      s_nxt.xst       = XS_IDLE;
      s_nxt.req       = 1'b0;
      s_nxt.drv       = 1'b0;
      s_nxt.cnt       = '0;
      s_nxt.wp        = 1'b0;
      s_nxt.rp        = 1'b0;
      s_nxt.stop_pulse = 1'b0;
    end else if (s_r.in_reset) begin
      if (s_r.rst_cnt <= 8'h1) begin
        s_nxt.in_reset = 1'b0;
        s_nxt.abort    = 1'b0;
        s_nxt.busy     = 1'b0;
      end else begin
        s_nxt.rst_cnt = s_r.rst_cnt - 1'b1;
      end
    end

    // Registered views for the outputs
    s_nxt.blk_out  = s_nxt.blk_cnt != '0;
    s_nxt.end_out  = s_nxt.end_cnt != '0;
    s_nxt.id_out   = (ENG_ID_ACTIVE_I & ~s_nxt.in_reset) | s_nxt.id_hold;
    s_nxt.rd_ready = ~s_nxt.exp_data & (s_nxt.cnt < 2'h2);
    s_nxt.wr_valid = s_nxt.exp_data & (s_nxt.cnt != 2'h0);
    s_nxt.wr_head  = s_nxt.fifo[s_nxt.rp];
    s_nxt.wr_last  = s_nxt.fifo_last[s_nxt.rp];

    // Error bus routing, settled one clock after a select change
    if (MUX_SELECT_I == MUX_DEAD) begin
      s_nxt.err_bus = s_r.dead;
    end else if (MUX_SELECT_I == MUX_RWERR) begin
      s_nxt.err_bus = s_r.rw;
    end else if (MUX_SELECT_I == MUX_DIAG) begin
      s_nxt.err_bus = thp_diag_t'{pulse_a: ENG_PULSE_A_I, diag_aid_hi: ENG_DIAG_AID_I,
                        reject_code: s_r.rej_code};
    end else if (MUX_SELECT_I == MUX_SENSE) begin
      s_nxt.err_bus = {ENG_SENSE_I[8:6], 1'b0, ENG_SENSE_I[4:0]};
    end else begin
      s_nxt.err_bus = '0;
    end
  end

  //----------------------------------------------------------------------------
  // State register
  //----------------------------------------------------------------------------

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  //----------------------------------------------------------------------------
  // Outputs
  //----------------------------------------------------------------------------

  assign DATA_O              = {s_r.dout.par, rev8(s_r.dout.val)};
  assign DATA_OE_O           = s_r.drv;
  assign BUSY_O              = s_r.busy;
  assign XFER_REQUEST_O      = s_r.req;
  assign EXPECTING_DATA_O    = s_r.exp_data;
  assign BLOCK_SENSED_O      = s_r.blk_out;
  assign END_OF_DATA_PULSE_O = s_r.end_out;
  assign OSC_OUT_O           = s_r.osc;
  assign ID_BURST_ACTIVE_O   = s_r.id_out;
  assign TAPE_MARK_O         = s_r.tape_mark;
  assign REJECT_O            = s_r.reject;
  assign OP_INCOMPLETE_O     = s_r.op_incomplete;
  assign OVERRUN_FLAG_O      = s_r.overrun;
  assign STATUS_CHANGE_O     = s_r.stat_chg;
  assign DATA_CHECK_FLAG_O   = s_r.data_check_flag;
  assign ERROR_BUS_O         = s_r.err_bus;
  assign ENG_CMD_VALID_O     = s_r.cmd_pulse;
  assign ENG_CMD_O           = s_r.cmd;
  assign ENG_ABORT_O         = s_r.abort;
  assign ENG_STOP_O          = s_r.stop_pulse;
  assign ENG_RD_READY_O      = s_r.rd_ready;
  assign ENG_WR_VALID_O      = s_r.wr_valid;
  assign ENG_WR_DATA_O       = s_r.wr_head.val;
  assign ENG_WR_LAST_O       = s_r.wr_last;

endmodule : thp_host_port

// ---- hdl/thp_pkg.sv ----
//------------------------------------------------------------------------------
// Function
// - Host reset aborts command, busy refuses commands
// - Reset clears status, stops engine, leaves diagnostics
// - Select code routes one of four bytes
// - Error bus settles within 150 ns
// - Odd parity, line 7 least significant
// - Data stable 90 ns before strobe
// - Request raised for every moved character
// - Expecting data only for write commands
// - 400 ns pulse per sensed block
// - Free running 2.5 MHz oscillator output
// - 800 ns end pulse after read's last
// - Busy from accepted start until done/reject
// - Id burst line during identification, held on failure
// - Backward reaching start sets id burst, data check
// - Tape mark flag, cleared except clear/sense/no-op
// - Reject code shown in diagnostic aid byte
// - Op incomplete with reject when command started
// - Overrun flag on starved or overflowed buffer
// - Status change on online/offline/ready, cleared
// - Data check on listed error conditions
// - Fixed error bus bit map per byte
// - Request held until acknowledge or stop
//------------------------------------------------------------------------------
package thp_pkg;

  // Timing figures
  localparam int CLK_PERIOD_NS  = 100;
  localparam int BLOCK_PULSE_NS = 400;
  localparam int END_PULSE_NS   = 800;
  localparam int OSC_PERIOD_NS  = 400;
  localparam int DATA_SETUP_NS  = 90;
  localparam int MUX_SETTLE_NS  = 150;
  localparam int CNT_W          = 4;
  localparam int RST_W          = 8;

  localparam logic [CNT_W-1:0] BLOCK_PULSE_CYC =
    CNT_W'((BLOCK_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] END_PULSE_CYC =
    CNT_W'((END_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] SETUP_CYC =
    CNT_W'((DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [1:0] OSC_HALF_CYC = 2'(OSC_PERIOD_NS / (2 * CLK_PERIOD_NS));
  localparam int MUX_SETTLE_CYC = MUX_SETTLE_NS / CLK_PERIOD_NS;
  localparam logic [RST_W-1:0] RESET_PROC_DEF = 8'h10;

  // Select codes for the error bus
  localparam logic [2:0] MUX_DEAD  = 3'h0;
  localparam logic [2:0] MUX_RWERR = 3'h1;
  localparam logic [2:0] MUX_DIAG  = 3'h2;
  localparam logic [2:0] MUX_SENSE = 3'h3;

  // Command codes
  typedef enum logic [3:0] {
    CMD_NO_OP = 4'h0, CMD_DRIVE_CLEAR = 4'h1, CMD_DIAG_SET = 4'h2, CMD_SENSE = 4'h3,
    CMD_READ_FWD = 4'h4, CMD_READ_BWD = 4'h5, CMD_WRITE_BLOCK = 4'h6, CMD_LOOP_WR = 4'h7,
    CMD_BACK_FILE = 4'h8, CMD_SPACE_BACK_BLOCK = 4'h9, CMD_FWD_FILE = 4'ha,
    CMD_SPACE_FWD_BLOCK = 4'hb, CMD_WRITE_TM = 4'hc, CMD_ERASE_GAP = 4'hd,
    CMD_REWIND = 4'he, CMD_REWIND_UNLOAD = 4'hf
  } thp_cmd_t;

  typedef enum {XS_IDLE, XS_SETUP, XS_REQ, XS_REL} thp_xst_t;

  typedef struct packed {
    logic       par;
    logic [7:0] val;
  } thp_char_t;

  // Error bus byte layouts, bit 8 first
  typedef struct packed {
    logic crc; logic write_tape_mark_cmd; logic uncorrectable_err; logic partial_record;
    logic multi_track_err; logic unused; logic end_data_err; logic velocity_err;
    logic diag_latch;
  } thp_rw_err_t;

  typedef struct packed {
    logic write_en; logic end_of_tape; logic begin_of_tape; logic unused;
    logic file_protect; logic backward_status; logic high_density; logic ready;
    logic online;
  } thp_sense_t;

  typedef struct packed {
    logic       pulse_a;
    logic [1:0] diag_aid_hi;
    logic [5:0] reject_code;
  } thp_diag_t;

  // One-cycle events from the tape engine
  typedef struct packed {
    logic crc; logic write_tape_mark_cmd; logic uncorrectable_err; logic partial_record;
    logic multi_track_err; logic end_data_err; logic velocity_err; logic bot_backward;
    logic pe_postamble; logic pe_track_err; logic overrun; logic tape_mark;
    logic block; logic id_fail;
  } thp_evt_t;

endpackage : thp_pkg

// ---- verification/thp_host_port_sva.sv ----
`timescale 1ns/1ps
module thp_host_port_sva
  import thp_pkg::*;
(
  input wire logic       CLK_I,
  input wire logic       SYS_RST_I,
  input wire logic       HOST_RST_I,
  input wire logic       START_I,
  input wire thp_cmd_t   CMD_I,
  input wire logic [2:0] MUX_SELECT_I,
  input wire logic       XFER_ACK_I,
  input wire logic       STOP_I,
  input wire logic [8:0] DATA_O,
  input wire logic       DATA_OE_O,
  input wire logic       BUSY_O,
  input wire logic       XFER_REQUEST_O,
  input wire logic       EXPECTING_DATA_O,
  input wire logic       END_OF_DATA_PULSE_O,
  input wire logic       OSC_OUT_O,
  input wire logic [8:0] ERROR_BUS_O
);
  // ----
  // Port checks
  // ----
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  sequence s_take;
    START_I && !BUSY_O && !HOST_RST_I;
  endsequence
  sequence s_osc_low;
    !OSC_OUT_O [*2] ##1 OSC_OUT_O;
  endsequence
  a_busy_take: assert property (s_take |=> BUSY_O)
    else $error("busy not raised");
  a_rst_busy: assert property (HOST_RST_I |=> BUSY_O)
    else $error("busy low in host reset");
  a_rst_clear: assert property (HOST_RST_I |=> !XFER_REQUEST_O && !DATA_OE_O
    && !EXPECTING_DATA_O && !END_OF_DATA_PULSE_O) else $error("status not cleared");
  a_req_hold: assert property (XFER_REQUEST_O && !XFER_ACK_I && !STOP_I
    && !HOST_RST_I |=> XFER_REQUEST_O) else $error("request dropped early");
  a_odd_par: assert property (DATA_OE_O |-> ^DATA_O)
    else $error("even parity on data");
  a_rd_setup: assert property ($rose(XFER_REQUEST_O) && DATA_OE_O
    |-> $past(DATA_OE_O) && $stable(DATA_O)) else $error("no data setup");
  a_osc_wave: assert property ($rose(OSC_OUT_O) |=> OSC_OUT_O ##1 s_osc_low)
    else $error("oscillator period wrong");
  a_mux_zero: assert property ($past(MUX_SELECT_I[2]) |-> ERROR_BUS_O == 9'h000)
    else $error("unknown select not zero");
  a_mux_unused: assert property ($past(MUX_SELECT_I) == 3'h1 |-> !ERROR_BUS_O[3])
    else $error("unused bit driven");
  a_expecting_data_cmd: assert property (s_take |=> EXPECTING_DATA_O ==
    ($past(CMD_I) inside {CMD_WRITE_BLOCK, CMD_LOOP_WR})) else $error("expecting wrong");
  a_expecting_data_hold: assert property (EXPECTING_DATA_O && !START_I && !HOST_RST_I
    |=> EXPECTING_DATA_O) else $error("expecting dropped");
  a_end_len: assert property (disable iff (SYS_RST_I || HOST_RST_I)
    $rose(END_OF_DATA_PULSE_O) |-> END_OF_DATA_PULSE_O [*8] ##1 !END_OF_DATA_PULSE_O)
    else $error("end pulse length wrong");
endmodule : thp_host_port_sva

bind thp_host_port thp_host_port_sva chk_u (.CLK_I, .SYS_RST_I, .HOST_RST_I, .START_I,
  .CMD_I, .MUX_SELECT_I, .XFER_ACK_I, .STOP_I, .DATA_O, .DATA_OE_O, .BUSY_O,
  .XFER_REQUEST_O, .EXPECTING_DATA_O, .END_OF_DATA_PULSE_O, .OSC_OUT_O, .ERROR_BUS_O);

// ---- verification/thp_host_model.sv ----
`timescale 1ns/1ps
module thp_host_model
  import thp_pkg::*;
(
  input  wire logic       CLK_I,
  input  wire logic       req_i,
  input  wire logic [2:0] dly_i,
  input  wire logic       last_i,
  input  wire logic [7:0] wd_i,
  output logic            ack_o,
  output logic            stop_o,
  output logic      [8:0] wr_o
);
  // ----
  // Host side of the handshake
  // ----
  int w = 0;
  initial begin
    ack_o = 1'b0;
    stop_o = 1'b0;
    wr_o = 9'h155;
  end
  // Answer after dly_i + 1 cycles, release once the request drops
  always @(negedge CLK_I) begin
    if (ack_o || stop_o) begin
      if (!req_i) begin
        ack_o <= 1'b0;
        stop_o <= 1'b0;
      end
    end else if (req_i) begin
      if (w == 0) wr_o <= {~^wd_i, wd_i};
      if (w > dly_i) begin
        ack_o <= !last_i;
        stop_o <= last_i;
        w = 0;
      end else begin
        w = w + 1;
      end
    end else begin
      wr_o <= ~wr_o; // Idle bus never holds a stale value
    end
  end
endmodule : thp_host_model

// ---- verification/tb_tape_host_status_port.sv ----
`timescale 1ns/1ps
module tb_tape_host_status_port;
  import thp_pkg::*;
  // ----
  // Stimulus and checking
  // ----
  logic clk = 1'b0, rst = 1'b1, hrst = 1'b0, start = 1'b0, done = 1'b0, rej = 1'b0;
  logic inc = 1'b0, dset = 1'b0, pa = 1'b0, rv = 1'b0, rl = 1'b0, wrdy = 1'b0;
  logic ack, stop, oe, busy, req, expecting_data, blk, eod, tm, rj, oi, ovr, status_change, dchk, idb;
  logic rrdy, wv, wl, lst, cv, abt;
  logic [1:0] aid = 2'h0;
  logic [2:0] sel = 3'h0, dly = 3'h1;
  logic [5:0] code = 6'h00;
  logic [7:0] rd = 8'h00, wd = 8'h00, wdat;
  logic [8:0] din, hd, dout, eb, dv, dead = 9'h000;
  logic [6:0] flg;
  thp_cmd_t cm = CMD_NO_OP, ec;
  thp_cmd_t tl[4] = '{CMD_SENSE, CMD_DRIVE_CLEAR, CMD_NO_OP, CMD_READ_BWD};
  thp_evt_t e, evt = '0;
  thp_sense_t sense_cmd = '0;
  int bad_count = 0, check_count = 0, nw = 0, n;
  logic [8:0] rq[$], wq[$];
  assign din = oe ? dout : hd;
  assign lst = expecting_data && nw == 5;
  assign flg = {rj, oi, ovr, status_change, dchk, idb, tm};
  always #50 clk = ~clk;
  thp_host_port #(.RESET_PROC_CYCLES(8'h02)) dut_u (.CLK_I(clk), .SYS_RST_I(rst),
    .HOST_RST_I(hrst), .START_I(start), .CMD_I(cm), .MUX_SELECT_I(sel), .XFER_ACK_I(ack),
    .STOP_I(stop), .DATA_I(din), .DATA_O(dout), .DATA_OE_O(oe), .BUSY_O(busy),
    .XFER_REQUEST_O(req), .EXPECTING_DATA_O(expecting_data), .BLOCK_SENSED_O(blk),
    .END_OF_DATA_PULSE_O(eod), .OSC_OUT_O(), .ID_BURST_ACTIVE_O(idb), .TAPE_MARK_O(tm),
    .REJECT_O(rj), .OP_INCOMPLETE_O(oi), .OVERRUN_FLAG_O(ovr), .STATUS_CHANGE_O(status_change),
    .DATA_CHECK_FLAG_O(dchk), .ERROR_BUS_O(eb), .ENG_CMD_VALID_O(cv), .ENG_CMD_O(ec),
    .ENG_ABORT_O(abt), .ENG_STOP_O(), .ENG_DONE_I(done), .ENG_REJECT_I(rej),
    .ENG_REJ_CODE_I(code), .ENG_OP_INCOMPLETE_I(inc), .ENG_EVT_I(evt), .ENG_ID_ACTIVE_I(pa),
    .ENG_DIAG_SET_I(dset), .ENG_DIAG_AID_I(aid), .ENG_PULSE_A_I(pa), .ENG_DEAD_I(dead),
    .ENG_SENSE_I(sense_cmd), .ENG_RD_VALID_I(rv), .ENG_RD_DATA_I(rd), .ENG_RD_LAST_I(rl),
    .ENG_RD_READY_O(rrdy), .ENG_WR_VALID_O(wv), .ENG_WR_DATA_O(wdat), .ENG_WR_LAST_O(wl),
    .ENG_WR_READY_I(wrdy));
  thp_host_model host_u (.CLK_I(clk), .req_i(req), .dly_i(dly), .last_i(lst), .wd_i(wd),
    .ack_o(ack), .stop_o(stop), .wr_o(hd));
  function automatic logic [7:0] rev(input logic [7:0] b);
    for (int k = 0; k < 8; k++) rev[k] = b[7-k];
  endfunction : rev
  function automatic logic [8:0] oddp(input logic [7:0] b);
    return {~^b, rev(b)};
  endfunction : oddp
  function automatic logic dc(input thp_evt_t x);
    return |{x.crc, x.write_tape_mark_cmd, x.uncorrectable_err, x.partial_record, x.multi_track_err,
      x.end_data_err, x.velocity_err, x.overrun, x.bot_backward, x.pe_postamble,
      x.pe_track_err};
  endfunction : dc
  task automatic chk(input string s, input logic [8:0] got, input logic [8:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", s, exp, got);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc
  task automatic cmd(input thp_cmd_t c);
    cm <= c;
    start <= 1'b1;
    cyc(1);
    start <= 1'b0;
    chk("busy", 9'({busy, cv, ec}), 9'({2'h3, c}));
  endtask : cmd
  task automatic fin;
    done <= 1'b1;
    cyc(1);
    done <= 1'b0;
    cyc(2);
    chk("idle", 9'(busy), 9'h000);
  endtask : fin
  task automatic sb(input logic [2:0] s, input logic [8:0] x);
    sel <= s;
    cyc(1);
    chk("errbus", eb, x);
  endtask : sb
  task automatic push(input logic [7:0] b, input logic l);
    rd <= b;
    rl <= l;
    rv <= 1'b1;
    rq.push_back(oddp(b));
    do @(posedge clk); while (!rrdy);
    @(negedge clk);
  endtask : push
  task automatic close_out;
    if (bad_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out
  // Random host data and engine stalls
  always @(negedge clk) begin
    wd <= 8'($urandom);
    wrdy <= 1'($urandom);
  end
  // Characters crossing at the acknowledge edge and leaving to the engine
  always @(posedge clk) begin
    if (req && (ack || stop) && expecting_data) begin
      wq.push_back({stop, rev(din[7:0])});
      nw++;
    end else if (req && (ack || stop) && rq.size() > 0) chk("rdata", dout, rq.pop_front());
    if (wv && wrdy) chk("wdata", {wl, wdat}, wq.pop_front());
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    close_out();
  end
  initial begin
    void'($urandom(57));
    cyc(5);
    rst <= 1'b0;
    cyc(1);
    for (int i = 0; i < 6; i++) begin
      e = thp_evt_t'($urandom);
      dv = 9'($urandom);
      sense_cmd <= thp_sense_t'($urandom);
      cmd(CMD_REWIND);
      evt <= e;
      dead <= dv;
      dset <= 1'b1;
      sense_cmd.online <= ~sense_cmd.online;
      cyc(1);
      evt <= '0;
      dead <= 9'h000;
      dset <= 1'b0;
      {pa, aid, code} <= 9'($urandom);
      rej <= 1'b1;
      inc <= i[0];
      cyc(1);
      rej <= 1'b0;
      inc <= 1'b0;
      cyc(2);
      chk("flags", 9'(flg), 9'({1'b1, i[0], e.overrun, 1'b1, dc(e),
        pa | e.id_fail | e.bot_backward, e.tape_mark}));
      sb(3'h0, dv);
      sb(3'h1, {e.crc, e.write_tape_mark_cmd, e.uncorrectable_err, e.partial_record, e.multi_track_err, 1'b0,
        e.end_data_err, e.velocity_err, 1'b1});
      sb(3'h2, {pa, aid, code});
      sb(3'h3, 9'(sense_cmd) & 9'h1df);
      sb(3'(4 + i % 4), 9'h000);
    end
    cmd(CMD_SPACE_FWD_BLOCK);
    evt <= thp_evt_t'(14'h0006);
    cyc(1);
    evt <= '0;
    n = 0;
    repeat (6) begin
      n += blk;
      cyc(1);
    end
    chk("block", 9'(n), 9'h004);
    fin();
    for (int i = 0; i < 4; i++) begin
      cmd(tl[i]);
      chk("tmark", 9'(tm), 9'(i < 3));
      fin();
    end
    cmd(CMD_WRITE_BLOCK);
    chk("expecting_data", 9'(expecting_data), 9'h001);
    for (int k = 0; k < 900 && !(nw == 6 && wq.size() == 0); k++) cyc(1);
    chk("wcount", 9'(nw), 9'h006);
    fin();
    cmd(CMD_READ_FWD);
    chk("expecting_data", 9'(expecting_data), 9'h000);
    dly <= 3'h3;
    for (int k = 0; k < 4; k++) push(8'($urandom), k == 3);
    rv <= 1'b0;
    for (int k = 0; k < 300 && !eod; k++) cyc(1);
    chk("eod", 9'(eod), 9'h001);
    fin();
    sel <= 3'h1;
    cm <= CMD_WRITE_BLOCK;
    start <= 1'b1;
    hrst <= 1'b1;
    cyc(10);
    chk("rbusy", 9'({busy, abt}), 9'h003);
    chk("rflags", 9'({flg, eb[0]}), 9'h000);
    hrst <= 1'b0;
    cyc(1);
    start <= 1'b0;
    cyc(3);
    chk("refused", 9'({busy, expecting_data}), 9'h000);
    close_out();
  end
endmodule : tb_tape_host_status_port
